// ### rtl/isp_boot_and_code_banking.sv
// What this block does
// RL1: writing one to control bit 7 resets the device like the reset pin, then self-clears
// RL2: reading control bit 7 returns the hardware reboot indicator, not the trigger
// RL3: control bit 5 is read-only: 0 running application flash, 1 running loader flash
// RL4: control bit 1 is write-only boot region select: 1 loader, 0 application
// RL5: control bit 0 set: programming mode, core idle, idle bit ignored
// RL6: clearing control bit 0 leaves programming mode and honours the idle bit again
// RL7: enable, select, then idle; when idle ends restart from the selected region
// RL8: banking bit 3 enables both application banks, a port 1 pin becomes A16
// RL9: A16 low fetches bank 0, high bank 1; bits 2-0 choose the pin, default P1.7
// RL10: banking bits 7-4 and control bits 6,4,3,2 are reserved without function
// RL11: writes to reserved bits are ignored and they read as zero
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module isp_boot_and_code_banking
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // core side
    input wire logic hw_reboot_i,
    input wire logic idle_req_i,
    input wire logic idle_wake_i,
    input wire logic [7:0] port1_i,
    output logic device_reset_o,
    output logic core_idle_o,
    output logic program_mode_o,
    output logic core_restart_o,
    output logic exec_loader_o,
    output logic code_a16_o
);

    // bus slave state, kept running while ce_i is low so no transfer stalls
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic wr_prog_ff;
    logic upd_valid_ff;
    logic upd_prog_ff;
    logic [7:0] upd_data_ff;

    // block state, frozen while ce_i is low
    isp_boot_pkg::prog_ctrl_t prog_ff;
    isp_boot_pkg::bank_ctrl_t bank_ff;
    isp_boot_pkg::core_state_t state_ff;
    isp_boot_pkg::core_state_t nxt_state;
    logic soft_rst_ff;
    logic [isp_boot_pkg::SOFT_RST_CW-1:0] soft_cnt_ff;
    logic hw_reboot_ff;
    logic exec_loader_ff;
    logic boot_init_ff;
    logic core_idle_ff;
    logic program_mode_ff;
    logic core_restart_ff;
    logic code_a16_ff;

    logic addr_ok;
    logic take;
    logic take_read;
    logic take_write;
    logic [7:0] rd_prog;
    logic [7:0] rd_bank;
    logic upd_apply;
    logic trig_write;
    logic soft_done;

    // address decode: two words, everything else reads zero and ignores writes
    assign addr_ok = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0);
    assign take = hsel_i && hready_i && (htrans_i == isp_boot_pkg::HTRANS_NONSEQ)
        && (hsize_i == isp_boot_pkg::HSIZE_WORD);
    assign take_read = take && !hwrite_i;
    assign take_write = take && hwrite_i && addr_ok
        && ((haddr_i[9:2] == isp_boot_pkg::IDX_PROG_CTRL) || (haddr_i[9:2] == isp_boot_pkg::IDX_BANK_CTRL));

    // read views; reserved and write-only bits read as zero
    always_comb
    begin
        rd_prog = 8'h00; // [RL11]
        rd_prog[isp_boot_pkg::PC_TRIG_BIT] = hw_reboot_ff; // [RL2]
        rd_prog[isp_boot_pkg::PC_EXEC_BIT] = exec_loader_ff; // [RL3]
        rd_prog[isp_boot_pkg::PC_ENP_BIT] = prog_ff.program_mode_enable;
        rd_bank = 8'h00; // [RL10] [RL11]
        rd_bank[isp_boot_pkg::BC_EN_BIT] = bank_ff.en;
        rd_bank[isp_boot_pkg::BC_SEL_LSB +: isp_boot_pkg::BC_SEL_W] = bank_ff.sel;
    end

    // zero wait state slave, always okay; low only while reset is held
    always_ff @(posedge mclk_i)
    begin
        hreadyout_ff <= !rst_i;
    end

    // read data is driven in the data phase that follows the address phase
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            hrdata_ff <= 32'h00000000;
        end
        else if (take_read && addr_ok && haddr_i[9:2] == isp_boot_pkg::IDX_PROG_CTRL)
        begin
            hrdata_ff <= {24'h000000, rd_prog};
        end
        else if (take_read && addr_ok && haddr_i[9:2] == isp_boot_pkg::IDX_BANK_CTRL)
        begin
            hrdata_ff <= {24'h000000, rd_bank};
        end
        else
        begin
            hrdata_ff <= 32'h00000000;
        end
    end

    // write address phase remembered for the data phase
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wr_pend_ff <= 1'h0;
            wr_prog_ff <= 1'h0;
        end
        else if (hready_i)
        begin
            wr_pend_ff <= take_write;
            wr_prog_ff <= (haddr_i[9:2] == isp_boot_pkg::IDX_PROG_CTRL);
        end
    end

    // write data held until the block runs; a second write while frozen replaces it
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            upd_valid_ff <= 1'h0;
            upd_prog_ff <= 1'h0;
            upd_data_ff <= 8'h00;
        end
        else if (wr_pend_ff && hready_i)
        begin
            upd_valid_ff <= 1'h1;
            upd_prog_ff <= wr_prog_ff;
            upd_data_ff <= hwdata_i[7:0];
        end
        else if (ce_i)
        begin
            upd_valid_ff <= 1'h0;
        end
    end

    assign upd_apply = ce_i && upd_valid_ff && !soft_rst_ff;
    assign trig_write = upd_apply && upd_prog_ff && upd_data_ff[isp_boot_pkg::PC_TRIG_BIT];
    assign soft_done = soft_rst_ff && (soft_cnt_ff == isp_boot_pkg::SOFT_RST_CW'(isp_boot_pkg::SOFT_RST_CYCLES - 1));

    // soft reset: held as long as a pin reset, then clears itself
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            soft_rst_ff <= 1'h0;
            soft_cnt_ff <= '0;
        end
        else if (ce_i)
        begin
            if (trig_write)
            begin
                soft_rst_ff <= 1'h1; // [RL1]
                soft_cnt_ff <= '0;
            end
            else if (soft_done)
            begin
                soft_rst_ff <= 1'h0; // [RL1]
                soft_cnt_ff <= '0;
            end
            else if (soft_rst_ff)
            begin
                soft_cnt_ff <= soft_cnt_ff + 1'b1;
            end
        end
    end

    // control register; the soft reset returns it to its initial state
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            prog_ff <= '0;
        end
        else if (ce_i)
        begin
            if (soft_rst_ff)
            begin
                prog_ff <= '0; // [RL1]
            end
            else if (upd_apply && upd_prog_ff)
            begin
                prog_ff.boot_region_select <= upd_data_ff[isp_boot_pkg::PC_BOOT_REGION_SELECT_BIT]; // [RL4]
                prog_ff.program_mode_enable <= upd_data_ff[isp_boot_pkg::PC_ENP_BIT]; // [RL5] [RL6]
            end
        end
    end

    // banking register; only bits 3..0 are stored
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            bank_ff.en <= 1'h0;
            bank_ff.sel <= isp_boot_pkg::BC_SEL_RESET;
        end
        else if (ce_i)
        begin
            if (soft_rst_ff)
            begin
                bank_ff.en <= 1'h0;
                bank_ff.sel <= isp_boot_pkg::BC_SEL_RESET; // [RL9]
            end
            else if (upd_apply && !upd_prog_ff)
            begin
                bank_ff.en <= upd_data_ff[isp_boot_pkg::BC_EN_BIT]; // [RL8] [RL11]
                bank_ff.sel <= upd_data_ff[isp_boot_pkg::BC_SEL_LSB +: isp_boot_pkg::BC_SEL_W];
            end
        end
    end

    // reboot indicator follows the pin level
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            hw_reboot_ff <= 1'h0;
        end
        else if (ce_i)
        begin
            hw_reboot_ff <= hw_reboot_i; // [RL2]
        end
    end

    // core state: normal idle or programming idle, depending on the enable
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            isp_boot_pkg::ST_RUN:
            begin
                if (idle_req_i && prog_ff.program_mode_enable)
                begin
                    nxt_state = isp_boot_pkg::ST_PROG; // [RL7]
                end
                else if (idle_req_i)
                begin
                    nxt_state = isp_boot_pkg::ST_IDLE;
                end
            end
            isp_boot_pkg::ST_IDLE:
            begin
                if (idle_wake_i)
                begin
                    nxt_state = isp_boot_pkg::ST_RUN;
                end
            end
            isp_boot_pkg::ST_PROG:
            begin
                // the idle bit has no say here; only wake or disable leave
                if (idle_wake_i || !prog_ff.program_mode_enable)
                begin
                    nxt_state = isp_boot_pkg::ST_RUN; // [RL5] [RL6]
                end
            end
            default:
            begin
                nxt_state = isp_boot_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_ff <= isp_boot_pkg::ST_RUN;
        end
        else if (ce_i)
        begin
            if (soft_rst_ff)
            begin
                state_ff <= isp_boot_pkg::ST_RUN;
            end
            else
            begin
                state_ff <= nxt_state;
            end
        end
    end

    // restart pulse and executing region; a strap at reset release picks the first region
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            boot_init_ff <= 1'h1;
            exec_loader_ff <= 1'h0;
            core_restart_ff <= 1'h0;
        end
        else if (ce_i)
        begin
            core_restart_ff <= 1'h0;
            if (boot_init_ff || soft_done)
            begin
                boot_init_ff <= 1'h0;
                exec_loader_ff <= hw_reboot_i;
            end
            else if (state_ff == isp_boot_pkg::ST_PROG && idle_wake_i && !soft_rst_ff)
            begin
                exec_loader_ff <= prog_ff.boot_region_select; // [RL7] [RL3]
                core_restart_ff <= 1'h1; // [RL7]
            end
        end
    end

    // registered core controls
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            core_idle_ff <= 1'h0;
            program_mode_ff <= 1'h0;
        end
        else if (ce_i)
        begin
            core_idle_ff <= !soft_rst_ff && (nxt_state != isp_boot_pkg::ST_RUN); // [RL5]
            program_mode_ff <= !soft_rst_ff && prog_ff.program_mode_enable; // [RL5] [RL6]
        end
    end

    // bank address line from the chosen port 1 pin, low when banking is off
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            code_a16_ff <= 1'h0;
        end
        else if (ce_i)
        begin
            code_a16_ff <= bank_ff.en && port1_i[bank_ff.sel]; // [RL8] [RL9]
        end
    end

    assign hreadyout_o = hreadyout_ff;
    assign hrdata_o = hrdata_ff;
    assign hresp_o = isp_boot_pkg::HRESP_OKAY;
    assign device_reset_o = soft_rst_ff;
    assign core_idle_o = core_idle_ff;
    assign program_mode_o = program_mode_ff;
    assign core_restart_o = core_restart_ff;
    assign exec_loader_o = exec_loader_ff;
    assign code_a16_o = code_a16_ff;

endmodule

// ### rtl/isp_boot_pkg.sv
package isp_boot_pkg;

    // clock rate and a long soft-reset pulse
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned SOFT_RST_TIME_NS = 1000;
    localparam int unsigned SOFT_RST_CYCLES = (SOFT_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SOFT_RST_CW = $clog2(SOFT_RST_CYCLES + 1);

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PROG_CTRL = 8'h9F;
    localparam logic [7:0] IDX_BANK_CTRL = 8'hAB;

    // program_boot_control fields
    localparam int unsigned PC_TRIG_BIT = 7;
    localparam int unsigned PC_EXEC_BIT = 5;
    localparam int unsigned PC_BOOT_REGION_SELECT_BIT = 1;
    localparam int unsigned PC_ENP_BIT = 0;

    // code_bank_control fields
    localparam int unsigned BC_EN_BIT = 3;
    localparam int unsigned BC_SEL_LSB = 0;
    localparam int unsigned BC_SEL_W = 3;
    localparam logic [2:0] BC_SEL_RESET = 3'h7;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_IDLE = 2'b01,
        ST_PROG = 2'b10
    } core_state_t;

    typedef struct packed {
        logic boot_region_select;
        logic program_mode_enable;
    } prog_ctrl_t;

    typedef struct packed {
        logic en;
        logic [2:0] sel;
    } bank_ctrl_t;

endpackage

// ### sim/isp_boot_asserts.sv
`timescale 1ns/1ps
module isp_boot_asserts
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] port1_i,
    input wire logic idle_req_i,
    input wire logic idle_wake_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic device_reset_o,
    input wire logic core_idle_o,
    input wire logic program_mode_o,
    input wire logic core_restart_o,
    input wire logic exec_loader_o,
    input wire logic code_a16_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] rst_len_ff;
    // length of the soft reset pulse, cleared between pulses
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !device_reset_o)
            rst_len_ff <= 8'h00;
        else
            rst_len_ff <= rst_len_ff + 8'h01;
    end
    property p_ready;
        !$past(rst_i) |-> hreadyout_o && (hresp_o == isp_boot_pkg::HRESP_OKAY);
    endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_rst_len;
        $fell(device_reset_o) && !$past(rst_i) |-> rst_len_ff == 8'(isp_boot_pkg::SOFT_RST_CYCLES);
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("soft reset length wrong");
    property p_rst_prog;
        device_reset_o && $past(device_reset_o) |-> !program_mode_o;
    endproperty
    a_rst_prog: assert property (p_rst_prog) else $error("program mode kept in reset");
    property p_idle_cause;
        $rose(core_idle_o) |-> $past(idle_req_i) || $past(idle_req_i, 2);
    endproperty
    a_idle_cause: assert property (p_idle_cause) else $error("idle without request");
    // idle request dropping must not wake a programming core
    property p_hold_idle;
        core_idle_o && program_mode_o && !idle_wake_i && !$past(idle_wake_i) && !device_reset_o
            |=> core_idle_o || !program_mode_o || device_reset_o;
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("programming idle left");
    property p_restart;
        core_restart_o |-> $past(core_idle_o) && !core_idle_o ##1 !core_restart_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    property p_exec_change;
        $changed(exec_loader_o) && !$past(rst_i, 2) |-> core_restart_o || device_reset_o || $past(device_reset_o);
    endproperty
    a_exec_change: assert property (p_exec_change) else $error("exec region changed alone");
    property p_a16;
        $past(ce_i) && !$past(|port1_i) |-> !code_a16_o;
    endproperty
    a_a16: assert property (p_a16) else $error("a16 high with pins low");
    c_restart: cover property (core_restart_o && exec_loader_o);
    c_soft_reset_trigger: cover property ($fell(device_reset_o));
    c_a16: cover property (code_a16_o);
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk_i, rst_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic hw_reboot_i, idle_req_i, idle_wake_i;
    logic [7:0] port1_i;
    logic device_reset_o, core_idle_o, program_mode_o, core_restart_o, exec_loader_o, code_a16_o;
    int error_cnt;
    int checked;
    int n;
    localparam logic [31:0] A_PC = {22'h0, isp_boot_pkg::IDX_PROG_CTRL, 2'h0};
    localparam logic [31:0] A_BC = {22'h0, isp_boot_pkg::IDX_BANK_CTRL, 2'h0};
    isp_boot_and_code_banking uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hw_reboot_i(hw_reboot_i), .idle_req_i(idle_req_i), .idle_wake_i(idle_wake_i),
        .port1_i(port1_i), .device_reset_o(device_reset_o), .core_idle_o(core_idle_o),
        .program_mode_o(program_mode_o), .core_restart_o(core_restart_o), .exec_loader_o(exec_loader_o),
        .code_a16_o(code_a16_o));
    // 125 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // one single ahb-lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= isp_boot_pkg::HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= w;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1) @(posedge mclk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1) @(posedge mclk_i);
        rd = hrdata_o;
    endtask
    // extra edge so the write is visible to the next read
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge mclk_i);
    endtask
    task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic seen, input logic exp);
        cmp(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic rd_cmp(input string nm, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(nm, rd, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        {rst_i, ce_i, hsel_i, hwrite_i, hw_reboot_i, idle_req_i, idle_wake_i} = 7'h60;
        {haddr_i, hwdata_i, htrans_i, port1_i} = '0;
        hsize_i = isp_boot_pkg::HSIZE_WORD;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        hw_reboot_i <= 1'b1;
        // one edge for the indicator to pick up the pin
        @(posedge mclk_i);
        rd_cmp("pc_reset", A_PC, 32'h80);
        rd_cmp("bc_reset", A_BC, 32'h07);
        rd_cmp("unmapped", 32'h280, 32'h0);
        wr(A_PC, 32'h5E);
        rd_cmp("pc_reserved", A_PC, 32'h80);
        wr(A_BC, 32'hFFFFFFFA);
        rd_cmp("bc_reserved", A_BC, 32'h0A);
        hw_reboot_i <= 1'b0;
        $display("test registers done");
        // every pin choice as the bank line
        for (int s = 0; s < 8; s++)
        begin
            wr(A_BC, 32'h8 | s);
            port1_i <= 8'h01 << s;
            repeat (3) @(posedge mclk_i);
            cmp_bit("a16_high", code_a16_o, 1'b1);
            port1_i <= ~(8'h01 << s);
            repeat (3) @(posedge mclk_i);
            cmp_bit("a16_low", code_a16_o, 1'b0);
        end
        // frozen block keeps the bank line while the pin moves
        wr(A_BC, 32'h0F);
        port1_i <= 8'h80;
        repeat (3) @(posedge mclk_i);
        ce_i <= 1'b0;
        port1_i <= 8'h00;
        repeat (3) @(posedge mclk_i);
        cmp_bit("a16_frozen", code_a16_o, 1'b1);
        ce_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        cmp_bit("a16_thawed", code_a16_o, 1'b0);
        wr(A_BC, 32'h07);
        port1_i <= 8'hFF;
        repeat (3) @(posedge mclk_i);
        cmp_bit("a16_off", code_a16_o, 1'b0);
        port1_i <= 8'h00;
        $display("test banking done");
        // loader region first, then application region
        for (int s = 1; s >= 0; s--)
        begin
            wr(A_PC, {30'h0, s[0], 1'b1});
            idle_req_i <= 1'b1;
            repeat (3) @(posedge mclk_i);
            idle_req_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
            cmp_bit("prog_idle", core_idle_o, 1'b1);
            cmp_bit("prog_mode", program_mode_o, 1'b1);
            idle_wake_i <= 1'b1;
            @(posedge mclk_i);
            idle_wake_i <= 1'b0;
            n = 0;
            while (core_restart_o !== 1'b1 && n < 10)
            begin
                @(posedge mclk_i);
                n++;
            end
            cmp_bit("restart", core_restart_o, 1'b1);
            cmp_bit("exec_out", exec_loader_o, s[0]);
            rd_cmp("pc_exec", A_PC, {26'h0, s[0], 5'h01});
            wr(A_PC, 32'h0);
            // mode output follows the enable one edge after the register
            repeat (2) @(posedge mclk_i);
            cmp_bit("prog_left", program_mode_o, 1'b0);
        end
        idle_req_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        idle_req_i <= 1'b0;
        cmp_bit("norm_idle", core_idle_o, 1'b1);
        idle_wake_i <= 1'b1;
        @(posedge mclk_i);
        idle_wake_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        cmp_bit("norm_wake", core_idle_o, 1'b0);
        // clearing the enable wakes a programming core without a wake event
        wr(A_PC, 32'h01);
        idle_req_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        idle_req_i <= 1'b0;
        cmp_bit("dis_idle", core_idle_o, 1'b1);
        wr(A_PC, 32'h00);
        repeat (3) @(posedge mclk_i);
        cmp_bit("dis_wake", core_idle_o, 1'b0);
        cmp_bit("dis_mode", program_mode_o, 1'b0);
        $display("test programming done");
        hw_reboot_i <= 1'b1;
        wr(A_BC, 32'h0C);
        wr(A_PC, 32'h83);
        n = 0;
        while (device_reset_o !== 1'b1 && n < 10)
        begin
            @(posedge mclk_i);
            n++;
        end
        n = 0;
        while (device_reset_o === 1'b1 && n < 300)
        begin
            @(posedge mclk_i);
            n++;
        end
        cmp("rst_len", n, isp_boot_pkg::SOFT_RST_CYCLES);
        rd_cmp("pc_soft_reset_trigger", A_PC, 32'hA0);
        rd_cmp("bc_soft_reset_trigger", A_BC, 32'h07);
        $display("test soft reset done");
        print_verdict();
    end
endmodule
bind isp_boot_and_code_banking isp_boot_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .port1_i(port1_i), .idle_req_i(idle_req_i), .idle_wake_i(idle_wake_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .device_reset_o(device_reset_o), .core_idle_o(core_idle_o),
    .program_mode_o(program_mode_o), .core_restart_o(core_restart_o), .exec_loader_o(exec_loader_o),
    .code_a16_o(code_a16_o));
